//--- rtl/ser_pkg.sv
/*
 Package of the status and event reporting register bank.
 Holds bit positions, the reset value, register select codes and carrier structs.
 Assumes one system clock and a command decoder upstream that issues
 one-cycle command strobes to the bank.
*/
// Summary of operation
// [RULE1] Five eight-bit status registers readable by host.
// [RULE2] Clear-status command and power-on zero all five; the code leaves status bit 1 following the talk-only pin after clear-status.
// [RULE3] Event bit 7 sets after power cycle.
// [RULE4] Event bit 5 sets when command changes.
// [RULE5] Event bit 3 sets on command error.
// [RULE6] Event bit 0 sets when command completes.
// [RULE7] Unused event and status bits read zero.
// [RULE8] Status bit 5 is OR of enabled events.
// [RULE9] Host loads event mask by enable command.
// [RULE10] Status bit 6 sets on request, clears on poll.
// [RULE11] Status bit 5 ignores serial polls.
// [RULE12] Status bit 4 tracks pending output data.
// [RULE13] Status bit 2 is measurement summary except end.
// [RULE14] Status bit 1 shows talk-only mode.
// [RULE15] Status byte returned by poll or query.
// [RULE16] Enabled status bits assert service request.
// [RULE17] Host changes request mask by enable command.
// [RULE18] Measurement bits 7 end, 6 error.
// [RULE19] Measurement bits 5,4 secondary display under/over.
// [RULE20] Measurement bits 3,2 primary display under/over.
// [RULE21] Measurement bits 1 range down, 0 up.
// [RULE22] Event mask accepts and returns 0 to 255.
// [RULE23] Flags stay set until cleared.
package ser_pkg;

   localparam int unsigned SER_W = 8;

   // Event register bit positions.
   localparam int unsigned SER_EV_PON = 7;
   localparam int unsigned SER_EV_CME = 5;
   localparam int unsigned SER_EV_DDE = 3;
   localparam int unsigned SER_EV_OPC = 0;
   localparam logic [7:0]  SER_EV_USED = 8'h00_A9;

   // Status byte bit positions.
   localparam int unsigned SER_SB_RQS = 6;
   localparam int unsigned SER_SB_ESB = 5;
   localparam int unsigned SER_SB_MAV = 4;
   localparam int unsigned SER_SB_MSS = 2;
   localparam int unsigned SER_SB_TLK = 1;
   localparam logic [7:0]  SER_SB_USED = 8'h00_76;

   // Measurement status bit positions.
   localparam int unsigned SER_MS_END = 7;
   localparam logic [7:0]  SER_MS_SUMMARY_MASK = 8'h00_7F;

   localparam logic [7:0] SER_RESET_VAL = 8'h00_00;

   // Register select codes for reads and writes.
   typedef enum logic [2:0] {
      SER_SEL_EVENT   = 3'h0,
      SER_SEL_EV_EN   = 3'h1,
      SER_SEL_STATUS  = 3'h2,
      SER_SEL_SRQ_EN  = 3'h3,
      SER_SEL_MEAS    = 3'h4
   } ser_sel_t;

   // Hardware event strobes from the instrument core.
   typedef struct packed {
      logic       power_cycled;
      logic       command_changed;
      logic       command_error;
      logic       command_done;
      logic [7:0] meas_events;
   } ser_events_t;

   // Register access from the command decoder.
   typedef struct packed {
      logic       clear_status;
      logic       write_en;
      logic       read_en;
      logic       serial_poll;
      ser_sel_t   sel;
      logic [7:0] wdata;
   } ser_cmd_t;

   typedef struct packed {
      logic [7:0] event_status;
      logic [7:0] event_enable;
      logic [7:0] srq_enable;
      logic [7:0] meas_status;
      logic       request_service_flag;
      logic       message_available_flag;
      logic       srq_prev;
      logic [7:0] rdata;
      logic       rvalid;
   } ser_state_t;

endpackage

//--- rtl/ser_sync.sv
/*
 Two-flop synchroniser for pin-level inputs.
 Assumes an asynchronous input and one destination clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ser_sync
   import ser_pkg::*;
#(
   parameter int unsigned WIDTH = 1
)
(
   // Clock and reset.
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   // Data.
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;

   // Refused at elaboration, so a bad width never reaches silicon.
   generate
      if (WIDTH < 1)
      begin : g_bad_width
         $error("ser_sync width must be at least one.");
      end
   endgenerate

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_reg <= '0;
         sync_o   <= '0;
      end
      else
      begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end

endmodule
`default_nettype wire

//--- rtl/ser_status_bank.sv
/*
 Status and event reporting register bank of the instrument.
 Assumes command strobes and event strobes arrive on core_clk_i and
 the talk-only mode level arrives from a front-panel pin.
*/
`timescale 1ns/10ps
`default_nettype none
module ser_status_bank
   import ser_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // Command decoder side.
   input  wire ser_cmd_t    cmd_i,
   // Instrument core events.
   input  wire ser_events_t events_i,
   input  wire logic        output_ready_i,
   input  wire logic        output_read_i,
   // Pin level.
   input  wire logic        talk_only_i,
   // Answers.
   output logic [7:0]       rdata_o,
   output logic             rvalid_o,
   output logic [7:0]       status_byte_o,
   output logic             srq_low_o
);

   ser_state_t state_reg;
   ser_state_t state_next;
   logic       talk_only_sync;
   logic [7:0] sb_now;

   ser_sync #(.WIDTH(1)) u_talk_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .async_i    (talk_only_i),
      .sync_o     (talk_only_sync)
   );

   function automatic logic any_set(input logic [7:0] a, input logic [7:0] b);
      return |(a & b);
   endfunction

   // Status byte assembled from live state; unused bits forced zero.
   always_comb
   begin
      sb_now                = SER_RESET_VAL;
      sb_now[SER_SB_RQS]    = state_reg.request_service_flag;                                           // [RULE10]
      sb_now[SER_SB_ESB]    = any_set(state_reg.event_status, state_reg.event_enable); // [RULE8] [RULE11]
      sb_now[SER_SB_MAV]    = state_reg.message_available_flag;                                           // [RULE12]
      sb_now[SER_SB_MSS]    = any_set(state_reg.meas_status, SER_MS_SUMMARY_MASK);     // [RULE13]
      sb_now[SER_SB_TLK]    = talk_only_sync;                                          // [RULE14]
      sb_now                = sb_now & SER_SB_USED;                                    // [RULE7]
   end

   always_comb
   begin
      logic [7:0] ev_set;
      logic       srq_want;
      ev_set     = SER_RESET_VAL;
      srq_want   = 1'b0;
      state_next = state_reg;
      state_next.rvalid = 1'b0;

      ev_set[SER_EV_PON] = events_i.power_cycled;    // [RULE3]
      ev_set[SER_EV_CME] = events_i.command_changed; // [RULE4]
      ev_set[SER_EV_DDE] = events_i.command_error;   // [RULE5]
      ev_set[SER_EV_OPC] = events_i.command_done;    // [RULE6]

      // The service request excludes bit 6 itself so it cannot latch itself.
      srq_want = any_set(sb_now, state_reg.srq_enable & ~(8'h01 << SER_SB_RQS)); // [RULE16]
      state_next.srq_prev = srq_want;

      if (cmd_i.clear_status)
      begin
         state_next.event_status = SER_RESET_VAL; // [RULE2]
         state_next.event_enable = SER_RESET_VAL; // [RULE2]
         state_next.srq_enable   = SER_RESET_VAL; // [RULE2]
         state_next.meas_status  = SER_RESET_VAL; // [RULE2]
         state_next.request_service_flag          = 1'b0;          // [RULE2]
         state_next.message_available_flag          = 1'b0;          // [RULE2]
      end
      else
      begin
         if (cmd_i.write_en && cmd_i.sel == SER_SEL_EV_EN)
         begin
            state_next.event_enable = cmd_i.wdata; // [RULE22]
         end
         if (cmd_i.write_en && cmd_i.sel == SER_SEL_SRQ_EN)
         begin
            state_next.srq_enable = cmd_i.wdata; // [RULE16]
         end
         if (cmd_i.serial_poll)
         begin
            state_next.request_service_flag = 1'b0; // [RULE10]
         end
         if (output_read_i)
         begin
            state_next.message_available_flag = 1'b0; // [RULE12]
         end
      end

      // Sets are applied last so that an event never loses to a clear.
      state_next.event_status = (state_next.event_status | ev_set) & SER_EV_USED;  // [RULE23] [RULE7]
      state_next.meas_status  = state_next.meas_status | events_i.meas_events;      // [RULE18] [RULE19] [RULE20] [RULE21] [RULE23]
      if (output_ready_i)
      begin
         state_next.message_available_flag = 1'b1; // [RULE12]
      end
      if (srq_want && !state_reg.srq_prev)
      begin
         state_next.request_service_flag = 1'b1; // [RULE10] [RULE16]
      end

      if (cmd_i.read_en || cmd_i.serial_poll)
      begin
         state_next.rvalid = 1'b1; // [RULE15]
         unique case (cmd_i.serial_poll ? SER_SEL_STATUS : cmd_i.sel)
            SER_SEL_EVENT:  state_next.rdata = state_reg.event_status; // [RULE1]
            SER_SEL_EV_EN:  state_next.rdata = state_reg.event_enable; // [RULE22]
            SER_SEL_STATUS: state_next.rdata = sb_now;                 // [RULE15]
            SER_SEL_SRQ_EN: state_next.rdata = state_reg.srq_enable;
            SER_SEL_MEAS:   state_next.rdata = state_reg.meas_status;
            default:        state_next.rdata = SER_RESET_VAL;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_reg <= '0; // [RULE2]
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign rdata_o       = state_reg.rdata;
   assign rvalid_o      = state_reg.rvalid;
   assign status_byte_o = sb_now;
   assign srq_low_o     = state_reg.request_service_flag;

endmodule
`default_nettype wire

//--- sim/ser_status_bank_asserts.sv
/* Port checker of the status bank.
   Bound into ser_status_bank; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module ser_status_bank_asserts
   import ser_pkg::*;
(
   // Watched ports.
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   input wire ser_cmd_t    cmd_i,
   input wire ser_events_t events_i,
   input wire logic        output_ready_i,
   input wire logic [7:0]  rdata_o,
   input wire logic        rvalid_o,
   input wire logic [7:0]  status_byte_o,
   input wire logic        srq_low_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   a_unused_zero: assert property ((status_byte_o & 8'h89) == 8'h00) else $error("unused bit set");
   a_read_answer: assert property (cmd_i.read_en |=> rvalid_o) else $error("no read answer");
   a_answer_cause: assert property (rvalid_o |-> $past(cmd_i.read_en || cmd_i.serial_poll))
      else $error("answer without request");
   a_poll_data: assert property (cmd_i.serial_poll |=> rdata_o == $past(status_byte_o)) else $error("bad poll");
   a_srq_line: assert property (srq_low_o == status_byte_o[6]) else $error("request line wrong");
   a_srq_hold: assert property (srq_low_o && !cmd_i.serial_poll && !cmd_i.clear_status |=> srq_low_o)
      else $error("request dropped without poll");
   a_mav_set: assert property (output_ready_i |=> status_byte_o[4]) else $error("message flag low");
   a_meas_sum: assert property (|events_i.meas_events[6:0] |=> status_byte_o[2]) else $error("summary low");
   a_clear_zero: assert property (cmd_i.clear_status && !events_i |=> !(status_byte_o & 8'h64))
      else $error("clear left bits set");
endmodule
bind ser_status_bank ser_status_bank_asserts u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_i(cmd_i),
   .events_i(events_i), .output_ready_i(output_ready_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
   .status_byte_o(status_byte_o), .srq_low_o(srq_low_o));
`default_nettype wire

//--- sim/ser_host_model.sv
/* Host model that drives the command port.
   Assumes the bench runs core_clk_i. */
`timescale 1ns/10ps
`default_nettype none
module ser_host_model
   import ser_pkg::*;
(
   // Clock.
   input  wire logic       core_clk_i,
   // Command and answer.
   output var ser_cmd_t    cmd_o,
   input  wire logic       rvalid_i,
   input  wire logic [7:0] rdata_i
);
   initial cmd_o = '0;
   // Masks change only by enable or clear-status commands; a missing answer reads as inverted data.
   task automatic issue(input logic [3:0] k, input logic [2:0] s, input logic [7:0] w, output logic [7:0] d);
      @(posedge core_clk_i) cmd_o <= {k, s, w};
      @(posedge core_clk_i) cmd_o <= '0;
      #1 d = rvalid_i ? rdata_i : ~rdata_i;
   endtask
endmodule
`default_nettype wire

//--- sim/tb_ser_status_bank.sv
/* Self-checking bench of the status bank.
   Assumes ser_pkg, the host model and the checker. */
`timescale 1ns/10ps
`default_nettype none
module tb_ser_status_bank
   import ser_pkg::*;
;
   logic        core_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        o_rdy = 1'b0, o_rd = 1'b0, talk = 1'b0, rv, srq;
   logic [7:0]  rdata, sb, d;
   ser_cmd_t    cmd;
   ser_events_t ev = '0;
   int          n_errors = 0, comparisons = 0;
   always #2 core_clk_i = ~core_clk_i;
   ser_status_bank DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_i(cmd), .events_i(ev), .output_ready_i(o_rdy),
      .output_read_i(o_rd), .talk_only_i(talk), .rdata_o(rdata), .rvalid_o(rv), .status_byte_o(sb), .srq_low_o(srq));
   ser_host_model host (.core_clk_i(core_clk_i), .cmd_o(cmd), .rvalid_i(rv), .rdata_i(rdata));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic t_events;
      host.issue(4'h2, 3'h0, 8'h00, d);
      chk("event", 8'h00, d);
      @(posedge core_clk_i) ev <= {4'hF, 8'h00};
      @(posedge core_clk_i) ev <= '0;
      host.issue(4'h4, 3'h0, 8'h56, d);
      host.issue(4'h2, 3'h0, 8'h00, d);
      chk("event", 8'hA9, d);
      host.issue(4'h4, 3'h1, 8'h56, d);
      chk("status", 8'h00, sb);
      host.issue(4'h4, 3'h1, 8'hFF, d);
      host.issue(4'h2, 3'h1, 8'h00, d);
      chk("event enable", 8'hFF, d);
      chk("status", 8'h20, sb);
   endtask
   task automatic t_srq;
      host.issue(4'h4, 3'h3, 8'h20, d);
      @(posedge core_clk_i) #1;
      chk("request line", 8'h01, {7'h00, srq});
      host.issue(4'h2, 3'h2, 8'h00, d);
      chk("status query", 8'h60, d);
      host.issue(4'h1, 3'h0, 8'h00, d);
      chk("poll", 8'h60, d);
      chk("status", 8'h20, sb);
   endtask
   task automatic t_meas;
      logic [7:0] acc = 8'h00;
      for (int i = 7; i >= 0; i--)
      begin
         acc[i] = 1'b1;
         @(posedge core_clk_i) ev <= {4'h0, 8'h01 << i};
         @(posedge core_clk_i) ev <= '0;
         host.issue(4'h2, 3'h4, 8'h00, d);
         chk("measure", acc, d);
         chk("summary", {5'h00, |acc[6:0], 2'h0}, sb & 8'h04);
      end
   endtask
   task automatic t_mav;
      @(posedge core_clk_i) {o_rdy, talk} <= 2'b11;
      @(posedge core_clk_i) o_rdy <= 1'b0;
      host.issue(4'h1, 3'h0, 8'h00, d);
      chk("status", 8'h36, sb);
      @(posedge core_clk_i) o_rd <= 1'b1;
      @(posedge core_clk_i) o_rd <= 1'b0;
      host.issue(4'h8, 3'h0, 8'h00, d);
      chk("status", 8'h02, sb);
      host.issue(4'h2, 3'h3, 8'h00, d);
      chk("request enable", 8'h00, d);
      host.issue(4'h2, 3'h5, 8'h00, d);
      chk("unused select", 8'h00, d);
   endtask
   task automatic complete_run;
      if (n_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge core_clk_i);
      rst_i <= 1'b0;
      t_events();
      t_srq();
      t_meas();
      t_mav();
      complete_run();
   end
   // A thousand cycles, several times what the tests take.
   initial
   begin
      #4000;
      n_errors++;
      complete_run();
   end
endmodule
`default_nettype wire
